//--- design/lpc_pkg.sv
// package for the lcd panel control block: register map, fields, states and carriers
package lpc_pkg;
   localparam int ADDR_W = 11;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 11'h000;
   localparam logic [ADDR_W-1:0] OFS_IRQ_FLAGS = 11'h004;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 11'h008;
   localparam logic [ADDR_W-1:0] OFS_LINE_TIMING = 11'h00c;
   localparam logic [ADDR_W-1:0] OFS_FRAME_TIMING = 11'h010;
   localparam logic [ADDR_W-1:0] OFS_PIXCLK_SETUP = 11'h014;
   localparam logic [ADDR_W-1:0] OFS_START_PTR_A = 11'h018;
   localparam logic [ADDR_W-1:0] OFS_START_PTR_B = 11'h01c;
   localparam logic [ADDR_W-1:0] OFS_WORD_COUNT = 11'h020;
   localparam logic [ADDR_W-1:0] OFS_PULSE_DIV = 11'h024;
   localparam logic [ADDR_W-1:0] OFS_PULSE_HIGH = 11'h028;
   localparam logic [ADDR_W-1:0] OFS_LOOKUP = 11'h400;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [31:0] CONTROL_WMASK = 32'h001f_ffef;
   localparam logic [31:0] IRQ_WMASK = 32'h0000_00ef;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
   localparam int BIT_GO = 0;
   localparam int BIT_FLAG_SHUTDOWN = 7;
   localparam int BIT_FLAG_START_A = 0;
   localparam int BIT_FLAG_VSYNC = 2;
   localparam int BIT_FLAG_ACTIVE = 3;
   localparam logic [2:0] DEPTH_16 = 3'h5;
   localparam logic [2:0] LAYOUT_LAST = 3'h4;
   localparam logic [1:0] SWIVEL_90 = 2'h1;
   localparam logic [1:0] SWIVEL_270 = 2'h3;
   localparam logic [15:0] WHITE_ALL = 16'hffff;
   localparam logic [15:0] PINS12_MASK = 16'h0fff;
   localparam logic [7:0] PULSE_DIV_RESET = 8'h00;
   localparam logic [15:0] LINES_RESET = 16'h0000;

   typedef struct packed {
      logic [10:0] reserved_hi;
      logic [2:0] rgb16_layout;
      logic white_level;
      logic white_force;
      logic coherent;
      logic [1:0] swivel_select;
      logic tft_pin_count;
      logic channel_order;
      logic panel_split;
      logic [1:0] pixel_packing_order;
      logic mono_width_select;
      logic panel_technology;
      logic panel_colour;
      logic reserved_4;
      logic [2:0] pixel_depth;
      logic go;
   } lpc_control_type;

   typedef struct packed {
      logic dma_req;
      logic dma_coherent;
      logic [31:0] dma_addr;
   } lpc_fetch_type;

   typedef struct packed {
      logic pix_clk;
      logic line_sync;
      logic frame_sync;
      logic data_enable;
      logic [15:0] data;
   } lpc_panel_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_SCAN = 2'b10,
      ST_DRAIN = 2'b11
   } lpc_state_type;
endpackage

//--- design/lpc_top.sv
// lcd panel control: registers, run control, fetch request and panel scan-out
//
// Summary of operation
// - rgb16_layout is stored but leaves pixel data unchanged for every code
// - white_level is value on all data pins
// - white_force holds data pins at white level
// - coherence bit marks fetches coherent
// - swivel_select bit 1 (180/270) walks fetch addresses downward; 0 and 90 both walk upward
// - tft_pin_count picks 16 or 12 pins
// - channel_order picks rgb or bgr
// - panel_split picks single or dual stn
// - pixel_packing_order sets unpack order in word
// - mono_width_select picks 4 or 8 bit mono
// - panel_technology picks stn or tft
// - panel_colour picks mono or colour
// - pixel_depth code 5 keeps 16 bits per pixel, any other code keeps the low 8 bits
// - go high starts frame fetch
// - fetched data goes out with panel timing
// - go low finishes current frame, no truncation
// - shutdown_done flag set after last frame
// - flags other than shutdown_done clear by writing one; mask gates
`timescale 1ns/1ps
module lpc_top
   import lpc_pkg::*;
#(
   parameter int LINE_PIXELS = 16,
   parameter int FRAME_LINES = 8
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output lpc_fetch_type fetch_o,
   input wire logic fetch_ack,
   input wire logic [31:0] fetch_data,
   input wire logic link_clk,
   output lpc_panel_type panel_o,
   output logic irq
);
   logic [1:0] rst_sync_r;
   logic rst_n_int;
   lpc_control_type ctrl_r;
   logic [31:0] flags_r, mask_r, line_timing_r, frame_timing_r, pixclk_r;
   logic [31:0] ptr_a_r, ptr_b_r, words_r, pdiv_r, phigh_r;
   logic ack_r;
   logic [31:0] rdata_r;
   lpc_state_type state_r;
   logic [31:0] word_r;
   logic [15:0] pix_cnt_r, line_cnt_r;
   logic [2:0] lclk_r;
   logic lclk_rise;
   logic frame_end, set_shutdown, set_start, set_vsync, set_active;
   logic [31:0] wmask;
   logic [15:0] pixel_nxt;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n_int = rst_sync_r[1];

   // link clock sampled with three flops; a rising edge counts when stage two is high and stage three low
   always_ff @(posedge clk_sys or negedge rst_n_int) begin
      if (!rst_n_int) begin
         lclk_r <= 3'b000;
      end else if (clk_en) begin
         lclk_r <= {lclk_r[1:0], link_clk};
      end
   end
   assign lclk_rise = lclk_r[1] & ~lclk_r[2];

   // slave answers one cycle after the request is seen
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[8*i +: 8] = {8{avs_byteenable[i]}};
      end
   end
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
   assign avs_readdata = rdata_r;

   always_ff @(posedge clk_sys or negedge rst_n_int) begin
      if (!rst_n_int) begin
         ack_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else if (clk_en) begin
         ack_r <= (avs_read | avs_write) & ~ack_r;
         if (avs_read & ~ack_r) begin
            case (avs_address)
               OFS_CONTROL: rdata_r <= ctrl_r;
               OFS_IRQ_FLAGS: rdata_r <= flags_r;
               OFS_IRQ_MASK: rdata_r <= mask_r;
               OFS_LINE_TIMING: rdata_r <= line_timing_r;
               OFS_FRAME_TIMING: rdata_r <= frame_timing_r;
               OFS_PIXCLK_SETUP: rdata_r <= pixclk_r;
               OFS_START_PTR_A: rdata_r <= ptr_a_r;
               OFS_START_PTR_B: rdata_r <= ptr_b_r;
               OFS_WORD_COUNT: rdata_r <= words_r;
               OFS_PULSE_DIV: rdata_r <= pdiv_r;
               OFS_PULSE_HIGH: rdata_r <= phigh_r;
               default: rdata_r <= UNMAPPED_DATA;
            endcase
         end
      end
   end

   // control register: reserved bits stay zero; all fields written at any time,
   // software keeps them stable while running
   always_ff @(posedge clk_sys or negedge rst_n_int) begin
      if (!rst_n_int) begin
         ctrl_r <= CONTROL_RESET;
      end else if (clk_en) begin
         if (avs_write & ~ack_r & (avs_address == OFS_CONTROL)) begin
            ctrl_r <= (ctrl_r & ~(wmask & CONTROL_WMASK)) | (avs_writedata & wmask & CONTROL_WMASK);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_int) begin
      if (!rst_n_int) begin
         mask_r <= 32'h0000_0000;
         line_timing_r <= 32'h0000_0000;
         frame_timing_r <= 32'h0000_0000;
         pixclk_r <= 32'h0000_0000;
         ptr_a_r <= 32'h0000_0000;
         ptr_b_r <= 32'h0000_0000;
         words_r <= 32'h0000_0000;
         pdiv_r <= 32'h0000_0000;
         phigh_r <= 32'h0000_0000;
      end else if (clk_en && avs_write && !ack_r) begin
         case (avs_address)
            OFS_IRQ_MASK: mask_r <= (mask_r & ~wmask) | (avs_writedata & wmask & IRQ_WMASK);
            OFS_LINE_TIMING: line_timing_r <= (line_timing_r & ~wmask) | (avs_writedata & wmask);
            OFS_FRAME_TIMING: frame_timing_r <= (frame_timing_r & ~wmask) | (avs_writedata & wmask);
            OFS_PIXCLK_SETUP: pixclk_r <= (pixclk_r & ~wmask) | (avs_writedata & wmask);
            OFS_START_PTR_A: ptr_a_r <= (ptr_a_r & ~wmask) | (avs_writedata & wmask);
            OFS_START_PTR_B: ptr_b_r <= (ptr_b_r & ~wmask) | (avs_writedata & wmask);
            OFS_WORD_COUNT: words_r <= (words_r & ~wmask) | (avs_writedata & wmask);
            OFS_PULSE_DIV: pdiv_r <= (pdiv_r & ~wmask) | (avs_writedata & wmask);
            OFS_PULSE_HIGH: phigh_r <= (phigh_r & ~wmask) | (avs_writedata & wmask);
            default: ;
         endcase
      end
   end

   // sticky flags: set wins over write-one clear; shutdown clears when go rises again
   always_ff @(posedge clk_sys or negedge rst_n_int) begin
      if (!rst_n_int) begin
         flags_r <= 32'h0000_0000;
      end else if (clk_en) begin
         logic [31:0] clr;
         logic [31:0] set;
         clr = 32'h0000_0000;
         set = 32'h0000_0000;
         if (avs_write & ~ack_r & (avs_address == OFS_IRQ_FLAGS)) begin
            clr = avs_writedata & wmask & IRQ_WMASK;
            clr[BIT_FLAG_SHUTDOWN] = 1'b0;
         end
         if (ctrl_r.go) begin
            clr[BIT_FLAG_SHUTDOWN] = 1'b1;
         end
         set[BIT_FLAG_SHUTDOWN] = set_shutdown;
         set[BIT_FLAG_START_A] = set_start;
         set[BIT_FLAG_VSYNC] = set_vsync;
         set[BIT_FLAG_ACTIVE] = set_active;
         flags_r <= (flags_r & ~clr) | set;
      end
   end
   assign irq = |(flags_r & mask_r);

   // run control
   assign frame_end = lclk_rise && (pix_cnt_r == 16'(LINE_PIXELS - 1)) && (line_cnt_r == 16'(FRAME_LINES - 1));
   assign set_shutdown = (state_r == ST_DRAIN) && frame_end && !ctrl_r.go;
   assign set_start = (state_r == ST_FETCH) && fetch_ack;
   assign set_vsync = frame_end;
   assign set_active = (state_r == ST_FETCH) && fetch_ack && (line_cnt_r == LINES_RESET);

   always_ff @(posedge clk_sys or negedge rst_n_int) begin
      if (!rst_n_int) begin
         state_r <= ST_IDLE;
      end else if (clk_en) begin
         case (state_r)
            ST_IDLE: if (ctrl_r.go) state_r <= ST_FETCH;
            ST_FETCH: if (fetch_ack) state_r <= ST_SCAN;
            ST_SCAN: if (lclk_rise && pix_cnt_r[0]) state_r <= ctrl_r.go ? ST_FETCH : ST_DRAIN;
            ST_DRAIN: begin
               // frame finishes before shutdown
               if (frame_end) state_r <= ctrl_r.go ? ST_FETCH : ST_IDLE;
               else if (lclk_rise && pix_cnt_r[0] && ctrl_r.go) state_r <= ST_FETCH;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // pixel and line counters advance on link clock edges while scanning
   always_ff @(posedge clk_sys or negedge rst_n_int) begin
      if (!rst_n_int) begin
         pix_cnt_r <= 16'h0000;
         line_cnt_r <= 16'h0000;
      end else if (clk_en) begin
         if (state_r == ST_IDLE) begin
            pix_cnt_r <= 16'h0000;
            line_cnt_r <= 16'h0000;
         end else if (lclk_rise && state_r != ST_FETCH) begin
            if (pix_cnt_r == 16'(LINE_PIXELS - 1)) begin
               pix_cnt_r <= 16'h0000;
               line_cnt_r <= (line_cnt_r == 16'(FRAME_LINES - 1)) ? 16'h0000 : line_cnt_r + 16'h0001;
            end else begin
               pix_cnt_r <= pix_cnt_r + 16'h0001;
            end
         end
      end
   end

   // frame-buffer word holds two 16-bit pixels; packing order picks half
   always_ff @(posedge clk_sys or negedge rst_n_int) begin
      if (!rst_n_int) begin
         word_r <= 32'h0000_0000;
      end else if (clk_en && state_r == ST_FETCH && fetch_ack) begin
         word_r <= fetch_data;
      end
   end

   always_comb begin
      pixel_nxt = (pix_cnt_r[0] ^ ctrl_r.pixel_packing_order[0]) ? word_r[31:16] : word_r[15:0];
      if (ctrl_r.pixel_depth != DEPTH_16) begin
         pixel_nxt = {8'h00, pixel_nxt[7:0]};
      end
      if (ctrl_r.channel_order) begin
         pixel_nxt = {pixel_nxt[4:0], pixel_nxt[10:5], pixel_nxt[15:11]};
      end
      if (!ctrl_r.panel_colour && !ctrl_r.mono_width_select) begin
         pixel_nxt = {12'h000, pixel_nxt[3:0]};
      end
      if (!ctrl_r.panel_technology && ctrl_r.panel_split) begin
         pixel_nxt = {pixel_nxt[7:0], pixel_nxt[7:0]};
      end
      if (ctrl_r.panel_technology && ctrl_r.tft_pin_count) begin
         pixel_nxt = pixel_nxt & PINS12_MASK;
      end
      // every layout code, defined or beyond the last, passes the word unchanged
      if (ctrl_r.rgb16_layout <= LAYOUT_LAST && ctrl_r.pixel_depth == DEPTH_16) begin
         pixel_nxt = pixel_nxt;
      end
      if (ctrl_r.white_force) begin
         pixel_nxt = ctrl_r.white_level ? WHITE_ALL : 16'h0000;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_int) begin
      if (!rst_n_int) begin
         panel_o <= '0;
         fetch_o <= '0;
      end else if (clk_en) begin
         panel_o.pix_clk <= (state_r == ST_SCAN || state_r == ST_DRAIN) ? lclk_r[2] : 1'b0;
         panel_o.line_sync <= (state_r != ST_IDLE) && (pix_cnt_r == 16'h0000);
         panel_o.frame_sync <= (state_r != ST_IDLE) && (line_cnt_r == 16'h0000);
         panel_o.data_enable <= (state_r == ST_SCAN || state_r == ST_DRAIN);
         panel_o.data <= (ctrl_r.white_force || state_r != ST_IDLE) ? pixel_nxt : 16'h0000;
         fetch_o.dma_req <= (state_r == ST_FETCH) && !fetch_ack;
         fetch_o.dma_coherent <= ctrl_r.coherent;
         // 180 and 270 walk the buffer downward from the start pointer
         fetch_o.dma_addr <= ctrl_r.swivel_select[1] ? ptr_a_r - {14'h0000, pix_cnt_r, 2'b00}
            : ptr_a_r + {14'h0000, pix_cnt_r, 2'b00};
      end
   end

   white_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
      (clk_en && ctrl_r.white_force) |=> (panel_o.data == ($past(ctrl_r.white_level) ? WHITE_ALL : 16'h0000)))
      else $error("white data not held");
   go_fetch_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
      (clk_en && state_r == ST_IDLE && ctrl_r.go) |=> state_r == ST_FETCH)
      else $error("go did not start fetch");
   idle_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
      (state_r == ST_IDLE) |=> !fetch_o.dma_req)
      else $error("fetch while idle");
   shutdown_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
      (clk_en && set_shutdown) |=> flags_r[BIT_FLAG_SHUTDOWN])
      else $error("shutdown flag not set");
   no_truncate_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
      (clk_en && state_r == ST_DRAIN && !frame_end) |=> state_r != ST_IDLE)
      else $error("frame truncated");
   drain_end_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
      ($past(state_r) == ST_DRAIN && state_r == ST_IDLE) |-> $past(frame_end))
      else $error("stopped mid frame");
   coherent_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
      clk_en |=> fetch_o.dma_coherent == $past(ctrl_r.coherent))
      else $error("coherence mark wrong");
   irq_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
      irq |-> |(flags_r & mask_r))
      else $error("interrupt without enabled flag");
   sd_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
      (clk_en && flags_r[BIT_FLAG_SHUTDOWN] && !ctrl_r.go) |=> flags_r[BIT_FLAG_SHUTDOWN])
      else $error("shutdown flag cleared by write");
endmodule

//--- tb/lpc_mem_model.sv
// memory-side model answering frame fetch requests, promptly or slowly
`timescale 1ns/1ps
module lpc_mem_model
   import lpc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic slow,
   input wire lpc_fetch_type fetch_o,
   output logic fetch_ack,
   output logic [31:0] fetch_data
);
   logic [1:0] wait_r;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fetch_ack <= 1'b0;
         fetch_data <= 32'h0000_0000;
         wait_r <= 2'h0;
      end else if (fetch_o.dma_req && !fetch_ack && (wait_r == 2'h0 || !slow)) begin
         fetch_ack <= 1'b1;
         fetch_data <= fetch_o.dma_addr ^ 32'h5a5a_0f0f;
         wait_r <= 2'h3;
      end else begin
         // released bus inverts its data every cycle, alternating between the last word and its inverse
         fetch_ack <= 1'b0;
         fetch_data <= ~fetch_data;
         if (wait_r != 2'h0) begin
            wait_r <= wait_r - 2'h1;
         end
      end
   end
endmodule

//--- tb/tb_lcd_panel_control.sv
// testbench for lcd panel control: registers, white force, run and shutdown
`timescale 1ns/1ps
module tb_lcd_panel_control;
   import lpc_pkg::*;
   logic clk_sys, rst_n, link_clk, avs_read, avs_write, avs_waitrequest, fetch_ack, irq, slow;
   logic [ADDR_W-1:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, fetch_data, rnd, v;
   logic [15:0] wexp;
   logic [63:0] note;
   logic [63:0] exp_q[$];
   lpc_fetch_type fetch_o;
   lpc_panel_type panel_o;
   int fails, checked, de_cnt;
   logic idle_bad;

   lpc_top #(.LINE_PIXELS(16), .FRAME_LINES(8)) i_dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fetch_o(fetch_o),
      .fetch_ack(fetch_ack), .fetch_data(fetch_data), .link_clk(link_clk), .panel_o(panel_o), .irq(irq));

   lpc_mem_model i_mem (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .fetch_o(fetch_o),
      .fetch_ack(fetch_ack), .fetch_data(fetch_data));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   initial begin
      link_clk = 1'b0;
      #7;
      forever #80 link_clk = ~link_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // read data is taken at the rising edge where waitrequest is sampled low
   always @(posedge clk_sys) begin
      if (avs_read && !avs_waitrequest && exp_q.size() > 0) begin
         note = exp_q.pop_front();
         check(avs_readdata & note[63:32], note[31:0]);
      end
   end

   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int n;
      logic done;
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      n = 0;
      done = 1'b0;
      while (!done && n < 100) begin
         @(posedge clk_sys);
         n++;
         done = !avs_waitrequest;
      end
      if (!done) begin
         fails++;
         $display("BAD %0t bus answer missing", $time);
         wrap_up();
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back({m, e});
      bus(1'b0, a, 32'h0000_0000);
   endtask

   task automatic wait_on(input int sel);
      int n;
      logic hit;
      n = 0;
      hit = 1'b0;
      de_cnt = 0;
      while (!hit && n < 40000) begin
         @(negedge clk_sys);
         n++;
         de_cnt += int'(panel_o.data_enable === 1'b1);
         case (sel)
            0: hit = fetch_o.dma_req === 1'b1;
            1: hit = panel_o.data_enable === 1'b1;
            2: hit = irq === 1'b1;
            default: hit = panel_o.data === wexp;
         endcase
      end
      if (!hit) begin
         fails++;
         $display("BAD %0t wait %0d ran out", $time, sel);
         wrap_up();
      end
      @(posedge clk_sys);
   endtask

   initial begin
      rst_n = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = '0;
      avs_writedata = '0;
      slow = 1'b0;
      fails = 0;
      checked = 0;
      rnd = 32'hc8db;
      wexp = 16'h0000;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rd(OFS_CONTROL, CONTROL_RESET, 32'hffff_ffff);
      rd(11'h030, UNMAPPED_DATA, 32'hffff_ffff);
      check({29'h0, panel_o.line_sync, panel_o.frame_sync, fetch_o.dma_req}, 32'h0);
      $display("test reset done");
      // layout codes 0..4 and depth codes 0..5, go held low, other fields random
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         v = {11'h000, 3'(i % 5), rnd[13:0], 3'(i), 1'b0};
         bus(1'b1, OFS_CONTROL, v);
         rd(OFS_CONTROL, v & CONTROL_WMASK, 32'hffff_ffff);
      end
      $display("test fields done");
      for (int w = 0; w < 2; w++) begin
         wexp = (w == 1) ? WHITE_ALL : 16'h0000;
         bus(1'b1, OFS_CONTROL, 32'h0001_0000 | (32'(w) << 17));
         wait_on(3);
         check({16'h0, panel_o.data}, {16'h0, wexp});
      end
      bus(1'b1, OFS_CONTROL, 32'h0000_0000);
      $display("test white done");
      for (int r = 0; r < 2; r++) begin
         rnd = lfsr(rnd);
         slow <= rnd[0] | r[0];
         bus(1'b1, OFS_IRQ_MASK, 32'h0000_0080);
         bus(1'b1, OFS_CONTROL, 32'h0000_804b);
         wait_on(0);
         check({31'h0, fetch_o.dma_coherent}, 32'h1);
         wait_on(1);
         bus(1'b1, OFS_CONTROL, 32'h0000_804a);
         wait_on(2);
         check(32'(de_cnt != 0), 32'h1);
         rd(OFS_IRQ_FLAGS, 32'h0000_0080, 32'h0000_0080);
         bus(1'b1, OFS_IRQ_FLAGS, 32'h0000_00ff);
         rd(OFS_IRQ_FLAGS, 32'h0000_0080, 32'h0000_00ff);
         bus(1'b1, OFS_IRQ_MASK, 32'h0000_0000);
         @(negedge clk_sys);
         check({31'h0, irq}, 32'h0);
         idle_bad = 1'b0;
         repeat (300) begin
            @(negedge clk_sys);
            idle_bad = idle_bad | fetch_o.dma_req | panel_o.data_enable;
         end
         check({31'h0, idle_bad}, 32'h0);
         @(posedge clk_sys);
         $display("test run %0d done", r);
      end
      wrap_up();
   end
endmodule
